// file: adcmt_pkg.sv
// Package: register map, field positions, reset values, timing counts
// Assumes a 32-bit classic Wishbone slave port and a 200 MHz system clock
package adcmt_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCMT_OFF_MODE1 = 8'h00;
  localparam logic [7:0] ADCMT_OFF_MODE2 = 8'h04;
  localparam logic [7:0] ADCMT_OFF_MODE3 = 8'h08;
  localparam logic [7:0] ADCMT_OFF_START = 8'h0C;
  localparam logic [7:0] ADCMT_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADCMT_OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] ADCMT_OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADCMT_OFF_CORE_STAT = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ADCMT_M1_REF_EN = 7;
  localparam int ADCMT_M1_IDLE_RUN = 6;
  localparam int ADCMT_M1_LADDER = 5;
  localparam int ADCMT_M1_PRIO_SRC = 3;
  localparam int ADCMT_M1_PRIO_EN = 2;
  localparam int ADCMT_M1_NORM_SRC = 1;
  localparam int ADCMT_M1_NORM_EN = 0;
  localparam int ADCMT_M2_PRIO_LSB = 4;
  localparam int ADCMT_M2_NORM_LSB = 0;
  localparam int ADCMT_M3_ITM_LSB = 4;
  localparam int ADCMT_M3_REPEAT = 1;
  localparam int ADCMT_M3_SCAN = 0;
  localparam int ADCMT_ST_PRIO = 1;
  localparam int ADCMT_ST_NORM = 0;
  localparam int ADCMT_IRQ_CONV = 0;
  localparam int ADCMT_IRQ_ABORT = 1;
  localparam int ADCMT_IRQ_DROP = 2;
  localparam int ADCMT_CS_REF_READY = 0;
  localparam int ADCMT_CS_BUSY = 1;

  // Writable bits of mode registers one and three
  localparam logic [7:0] ADCMT_MODE1_MASK = 8'hEF;
  localparam logic [7:0] ADCMT_MODE3_MASK = 8'h73;
  // First forbidden channel code
  localparam logic [3:0] ADCMT_CH_LIMIT = 4'hC;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCMT_MODE1_RST = 8'h00;
  localparam logic [7:0] ADCMT_MODE2_RST = 8'h00;
  localparam logic [7:0] ADCMT_MODE3_RST = 8'h00;
  localparam logic [2:0] ADCMT_IRQ_RST = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ADCMT_CLK_PERIOD_NS = 5;
  localparam int ADCMT_REF_SETTLE_NS = 3000;
  localparam int ADCMT_REF_SETTLE_CYC =
    (ADCMT_REF_SETTLE_NS + ADCMT_CLK_PERIOD_NS - 1) / ADCMT_CLK_PERIOD_NS;
  localparam logic [9:0] ADCMT_REF_SETTLE_CNT =
    10'(ADCMT_REF_SETTLE_CYC);

  typedef enum logic {
    ADCMT_SRC_EXT = 1'b0,
    ADCMT_SRC_CAPTURE = 1'b1
  } adcmt_src_type;

endpackage : adcmt_pkg

// file: adcmt_edge_sync.sv
// Edge detector for an asynchronous pin, after a synchroniser chain
// Assumes the pin is slow against clk_i; one pulse per rising edge
module adcmt_edge_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic rise_o
);

  logic [STAGES-1:0] sync_reg;
  logic last_reg;

  // Only the chain's last flop feeds logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_reg <= '0;
      last_reg <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[STAGES-2:0], pin_i};
      last_reg <= sync_reg[STAGES-1];
      rise_o <= sync_reg[STAGES-1] & ~last_reg;
    end
  end

endmodule : adcmt_edge_sync

// file: adcmt_ctrl.sv
// Mode, trigger and channel control of a 12-input converter
// Assumes classic Wishbone on clk_i; core and capture units share clk_i
module adcmt_ctrl
  import adcmt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ext_trigger_i,
  input wire logic capture_unit_a_irq_i,
  input wire logic capture_unit_b_irq_i,
  input wire logic conv_done_i,
  input wire logic core_busy_i,
  input wire logic repeat_abort_i,
  input wire logic idle_mode_i,
  output logic reference_enable_o,
  output logic idle_run_enable_o,
  output logic core_halt_o,
  output logic ladder_current_on_o,
  output logic normal_start_o,
  output logic priority_start_o,
  output logic [3:0] normal_channel_o,
  output logic [3:0] priority_channel_o,
  output logic repeat_o,
  output logic scan_o,
  output logic conv_irq_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mode1_reg;
  logic [7:0] mode2_reg;
  logic [7:0] mode3_reg;
  logic [7:0] mode3_next;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_stat_next;
  logic [2:0] irq_en_reg;
  logic [2:0] interval_cnt_reg;
  logic [2:0] interval_cnt_next;
  logic [9:0] settle_cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic ref_ready_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire bus_req = cyc_i & stb_i;
  wire bus_wr = bus_req & ack_reg & we_i & sel_i[0];
  wire hit_mode1 = adr_i[7:2] == ADCMT_OFF_MODE1[7:2];
  wire hit_mode2 = adr_i[7:2] == ADCMT_OFF_MODE2[7:2];
  wire hit_mode3 = adr_i[7:2] == ADCMT_OFF_MODE3[7:2];
  wire hit_start = adr_i[7:2] == ADCMT_OFF_START[7:2];
  wire hit_stat = adr_i[7:2] == ADCMT_OFF_IRQ_STAT[7:2];
  wire hit_en = adr_i[7:2] == ADCMT_OFF_IRQ_EN[7:2];
  wire hit_clr = adr_i[7:2] == ADCMT_OFF_IRQ_CLR[7:2];
  wire hit_core = adr_i[7:2] == ADCMT_OFF_CORE_STAT[7:2];
  wire [7:0] wbyte = dat_i[7:0];

  // Unmapped and write-only offsets read as zero
  logic [7:0] rd_byte;
  assign rd_byte =
    hit_mode1 ? mode1_reg :
    hit_mode2 ? mode2_reg :
    hit_mode3 ? mode3_reg :
    hit_stat ? {5'h00, irq_stat_reg} :
    hit_en ? {5'h00, irq_en_reg} :
    hit_core ? {6'h00, core_busy_i, ref_ready_reg} :
    8'h00;

  // ----------------------------------------------------------------
  // Mode fields
  // ----------------------------------------------------------------
  wire ref_en = mode1_reg[ADCMT_M1_REF_EN];
  wire prio_src = mode1_reg[ADCMT_M1_PRIO_SRC];
  wire prio_en = mode1_reg[ADCMT_M1_PRIO_EN];
  wire norm_src = mode1_reg[ADCMT_M1_NORM_SRC];
  wire norm_en = mode1_reg[ADCMT_M1_NORM_EN];
  wire rep_bit = mode3_reg[ADCMT_M3_REPEAT];
  wire scan_bit = mode3_reg[ADCMT_M3_SCAN];
  wire [2:0] itm = mode3_reg[ADCMT_M3_ITM_LSB +: 3];
  wire fixed_rep = rep_bit & ~scan_bit;

  // Forbidden channel codes leave the field unchanged
  wire [3:0] wr_prio_ch = wbyte[ADCMT_M2_PRIO_LSB +: 4];
  wire [3:0] wr_norm_ch = wbyte[ADCMT_M2_NORM_LSB +: 4];
  wire [3:0] prio_ch_next = (wr_prio_ch < ADCMT_CH_LIMIT) ?
    wr_prio_ch : mode2_reg[ADCMT_M2_PRIO_LSB +: 4];
  wire [3:0] norm_ch_next = (wr_norm_ch < ADCMT_CH_LIMIT) ?
    wr_norm_ch : mode2_reg[ADCMT_M2_NORM_LSB +: 4];

  // Abort beats a same-cycle software write to the repeat bit
  always_comb begin
    mode3_next = mode3_reg;
    if (bus_wr && hit_mode3) begin
      mode3_next = wbyte & ADCMT_MODE3_MASK;
    end
    if (repeat_abort_i) begin
      mode3_next[ADCMT_M3_REPEAT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Start sources
  // ----------------------------------------------------------------
  logic ext_rise;

  adcmt_edge_sync #(
    .STAGES(2)
  ) u_ext_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_trigger_i),
    .rise_o(ext_rise)
  );

  wire sw_norm = bus_wr & hit_start & wbyte[ADCMT_ST_NORM];
  wire sw_prio = bus_wr & hit_start & wbyte[ADCMT_ST_PRIO];
  wire prio_pulse = (prio_src == ADCMT_SRC_CAPTURE) ?
    capture_unit_a_irq_i : ext_rise;
  wire norm_pulse = (norm_src == ADCMT_SRC_CAPTURE) ?
    capture_unit_b_irq_i : ext_rise;
  // Trigger already owned by priority conversion
  wire ext_owned = prio_en & (prio_src == ADCMT_SRC_EXT);
  wire norm_blocked = ext_owned & (norm_src == ADCMT_SRC_EXT);
  wire prio_hw_fire = prio_en & prio_pulse;
  wire norm_hw_fire =
    norm_en & norm_pulse & ~norm_blocked;
  wire ev_drop = norm_en & norm_pulse & norm_blocked;

  // ----------------------------------------------------------------
  // Conversion interrupt interval
  // ----------------------------------------------------------------
  wire interval_hit = interval_cnt_reg == itm;
  wire conv_fire = conv_done_i & (~fixed_rep | interval_hit);
  assign interval_cnt_next = (~fixed_rep | (conv_done_i & interval_hit)) ?
    3'h0 : interval_cnt_reg + {2'h0, conv_done_i};

  // Set wins over a same-cycle clear
  wire [2:0] irq_events = {ev_drop, repeat_abort_i, conv_fire};
  wire [2:0] irq_clr = (bus_wr & hit_clr) ? wbyte[2:0] : 3'h0;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_events;

  // ----------------------------------------------------------------
  // Bus slave: ack one cycle after the request, data with it
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      rdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode1_reg <= ADCMT_MODE1_RST;
      mode2_reg <= ADCMT_MODE2_RST;
      mode3_reg <= ADCMT_MODE3_RST;
    end else begin
      if (bus_wr && hit_mode1) begin
        mode1_reg <= wbyte & ADCMT_MODE1_MASK;
      end
      if (bus_wr && hit_mode2) begin
        mode2_reg <= {prio_ch_next, norm_ch_next};
      end
      mode3_reg <= mode3_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= ADCMT_IRQ_RST;
      irq_en_reg <= ADCMT_IRQ_RST;
      interval_cnt_reg <= 3'h0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (bus_wr && hit_en) begin
        irq_en_reg <= wbyte[2:0];
      end
      interval_cnt_reg <= interval_cnt_next;
    end
  end

  // Reference settle tracker, restarts whenever reference drops
  always_ff @(posedge clk_i) begin
    if (rst_i || !ref_en) begin
      settle_cnt_reg <= 10'h000;
      ref_ready_reg <= 1'b0;
    end else if (settle_cnt_reg == ADCMT_REF_SETTLE_CNT) begin
      ref_ready_reg <= 1'b1;
    end else begin
      settle_cnt_reg <= settle_cnt_reg + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Core-facing outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reference_enable_o <= 1'b0;
      idle_run_enable_o <= 1'b0;
      core_halt_o <= 1'b0;
      ladder_current_on_o <= 1'b0;
      normal_start_o <= 1'b0;
      priority_start_o <= 1'b0;
      normal_channel_o <= 4'h0;
      priority_channel_o <= 4'h0;
      repeat_o <= 1'b0;
      scan_o <= 1'b0;
      conv_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      reference_enable_o <= ref_en;
      idle_run_enable_o <= mode1_reg[ADCMT_M1_IDLE_RUN];
      core_halt_o <=
        idle_mode_i & ~mode1_reg[ADCMT_M1_IDLE_RUN];
      ladder_current_on_o <=
        mode1_reg[ADCMT_M1_LADDER] | core_busy_i;
      normal_start_o <= sw_norm | norm_hw_fire;
      priority_start_o <= sw_prio | prio_hw_fire;
      normal_channel_o <= mode2_reg[ADCMT_M2_NORM_LSB +: 4];
      priority_channel_o <= mode2_reg[ADCMT_M2_PRIO_LSB +: 4];
      repeat_o <= rep_bit;
      scan_o <= scan_bit;
      conv_irq_o <= conv_fire;
      irq_o <= |(irq_stat_reg & irq_en_reg);
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ack_pulse;
    ack_reg ##1 !ack_reg;
  endsequence

  sequence s_req_open;
    bus_req && !ack_reg;
  endsequence

  a_ack_single_pulse: assert property (s_req_open |=> s_ack_pulse)
    else $error("ack not a single pulse after request");

  a_mode1_reserved: assert property (
    mode1_reg[4] == 1'b0)
    else $error("reserved mode one bit set");

  a_prio_ch_legal: assert property (
    mode2_reg[7:4] < ADCMT_CH_LIMIT)
    else $error("priority channel holds forbidden code");

  a_norm_ch_legal: assert property (
    mode2_reg[3:0] < ADCMT_CH_LIMIT)
    else $error("normal channel holds forbidden code");

  a_prio_hw_gate: assert property (
    prio_pulse && !prio_en && !sw_prio |=> !priority_start_o)
    else $error("priority start while hardware start disabled");

  a_norm_hw_gate: assert property (
    norm_pulse && !norm_en && !sw_norm |=> !normal_start_o)
    else $error("normal start while hardware start disabled");

  a_ext_conflict: assert property (
    ext_rise && norm_blocked && norm_en && !sw_norm
    |=> priority_start_o == prio_en && !normal_start_o)
    else $error("external trigger started normal conversion");

  a_abort_clears: assert property (
    repeat_abort_i |=> !rep_bit ##1 !repeat_o)
    else $error("repeat bit survived abort");

  a_ladder_idle: assert property (
    !mode1_reg[ADCMT_M1_LADDER] && !core_busy_i |=> !ladder_current_on_o)
    else $error("ladder current on while idle");

  a_interval_skip: assert property (
    conv_done_i && fixed_rep && !interval_hit
    |=> !conv_irq_o && interval_cnt_reg == $past(interval_cnt_reg) + 3'h1)
    else $error("conversion interrupt before interval reached");

  a_single_every: assert property (
    conv_done_i && !fixed_rep |=> conv_irq_o && interval_cnt_reg == 3'h0)
    else $error("conversion interrupt missing outside fixed repeat");

  a_ref_drop: assert property (
    !ref_en |=> !ref_ready_reg ##1 !reference_enable_o || ref_en)
    else $error("reference ready while reference disabled");

endmodule : adcmt_ctrl

// file: adcmt_core_model.sv
// Converter core model: one conversion per start pulse taken while idle
// Assumes start and abort requests arrive on clk_i
module adcmt_core_model #(
  parameter int BUSY_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic abort_req_i,
  output logic conv_done_o,
  output logic core_busy_o,
  output logic repeat_abort_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Conversion timer
  // ------------------------------------------------------------
  logic [3:0] cnt_reg;
  // Starts while busy are lost, as in a real core
  always_ff @(posedge clk_i) begin
    conv_done_o <= 1'b0;
    repeat_abort_o <= abort_req_i & ~rst_i;
    if (rst_i) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
      conv_done_o <= (cnt_reg == 4'h1);
    end else if (start_i) begin
      cnt_reg <= 4'(BUSY_CYC);
    end
  end
  assign core_busy_o = (cnt_reg != 4'h0);
endmodule : adcmt_core_model

// file: adcmt_ctrl_test.sv
// Self-checking bench for the mode, trigger and channel control
// Assumes the core model answers starts; bus is classic Wishbone
module adcmt_ctrl_test
  import adcmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, ack_o, ext_i = 1'b0, idle_i = 1'b0;
  logic abort_req = 1'b0, done, busy, rabort;
  logic [1:0] hw_p = 2'h0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0, nch, pch;
  logic [31:0] dat_i = 32'h0, dat_o, seed = 32'h3837331e;
  logic ref_o, idle_o, halt_o, lad_o, ns_o, ps_o;
  logic rep_o, scan_o, cirq_o, irq_o;
  logic [31:0] exp_q[$];
  int n_fail = 0, cmp_count = 0, n_ns = 0, n_ps = 0, n_irq = 0;
  int cyc_cnt = 0;
  logic [7:0] m1_t[6] = '{8'h8C, 8'h88, 8'h83, 8'h82, 8'h81, 8'h85};
  int src_t[6] = '{0, 0, 1, 1, 2, 2};
  int en_t[6] = '{1, 0, 1, 0, 1, 1};
  int ep_t[6] = '{1, 0, 0, 0, 0, 1};
  logic [7:0] ch_w[5] = '{8'hBA, 8'hC5, 8'h5F, 8'hFF, 8'h00};
  logic [7:0] ch_e[5] = '{8'hBA, 8'hB5, 8'h55, 8'h55, 8'h00};

  adcmt_ctrl adcmt_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_trigger_i(ext_i),
    .capture_unit_a_irq_i(hw_p[0]), .capture_unit_b_irq_i(hw_p[1]),
    .conv_done_i(done), .core_busy_i(busy), .repeat_abort_i(rabort),
    .idle_mode_i(idle_i), .reference_enable_o(ref_o),
    .idle_run_enable_o(idle_o), .core_halt_o(halt_o),
    .ladder_current_on_o(lad_o), .normal_start_o(ns_o),
    .priority_start_o(ps_o), .normal_channel_o(nch),
    .priority_channel_o(pch), .repeat_o(rep_o), .scan_o(scan_o),
    .conv_irq_o(cirq_o), .irq_o(irq_o));
  adcmt_core_model adcmt_core_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(ns_o | ps_o), .abort_req_i(abort_req), .conv_done_o(done),
    .core_busy_o(busy), .repeat_abort_o(rabort));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    cmp_count++;
    if (got !== ex) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, ex);
      n_fail++;
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic w,
      input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(a, 1'b0, 32'h0);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic fire(input int s);
    @(posedge clk_i);
    if (s == 2) ext_i <= 1'b1;
    else hw_p <= (s == 0) ? 2'h1 : 2'h2;
    // Capture events are one-cycle pulses; the pin stays up longer
    @(posedge clk_i);
    hw_p <= 2'h0;
    repeat (2) @(posedge clk_i);
    ext_i <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask : fire
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction : xorshift
  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // Clock, monitor, counters, timeout
  // ------------------------------------------------------------
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, exp_q.pop_front());
    if (ns_o === 1'b1) n_ns++;
    if (ps_o === 1'b1) n_ps++;
    if (cirq_o === 1'b1) n_irq++;
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADCMT_OFF_MODE1, 32'h0);
    rd(ADCMT_OFF_MODE2, 32'h0);
    rd(ADCMT_OFF_MODE3, 32'h0);
    rd(8'h40, 32'h0);
    wb(ADCMT_OFF_MODE1, 1'b1, 32'hFFFFFFFF);
    rd(ADCMT_OFF_MODE1, 32'hEF);
    settle();
    chk(ref_o, 1);
    // Full settle time before any start
    repeat (610) @(posedge clk_i);
    rd(ADCMT_OFF_CORE_STAT, 32'h1);
    // Core idle here, so entering idle is safe
    idle_i <= 1'b1;
    settle();
    chk({idle_o, halt_o}, 2'b10);
    wb(ADCMT_OFF_MODE1, 1'b1, 32'h80);
    settle();
    chk({halt_o, lad_o}, 2'b10);
    @(posedge clk_i);
    idle_i <= 1'b0;
    n_ns = 0;
    wb(ADCMT_OFF_START, 1'b1, 32'h1);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(lad_o, 1);
    repeat (4) @(negedge clk_i);
    chk(lad_o, 0);
    chk(n_ns, 1);
    wb(ADCMT_OFF_MODE1, 1'b1, 32'hA0);
    settle();
    chk(lad_o, 1);
    for (int i = 0; i < 6; i++) begin
      wb(ADCMT_OFF_MODE1, 1'b1, {24'h0, m1_t[i]});
      n_ns = 0;
      n_ps = 0;
      fire(src_t[i]);
      chk(n_ps, ep_t[i]);
      chk(n_ns, en_t[i] - ep_t[i]);
    end
    // Blocked normal trigger and earlier conversions both latched
    rd(ADCMT_OFF_IRQ_STAT, 32'h5);
    for (int i = 0; i < 5; i++) begin
      wb(ADCMT_OFF_MODE2, 1'b1, {24'h0, ch_w[i]});
      rd(ADCMT_OFF_MODE2, {24'h0, ch_e[i]});
      settle();
      chk({pch, nch}, ch_e[i]);
    end
    wb(ADCMT_OFF_MODE1, 1'b1, 32'h83);
    wb(ADCMT_OFF_IRQ_CLR, 1'b1, 32'h7);
    wb(ADCMT_OFF_IRQ_EN, 1'b1, 32'h1);
    settle();
    chk(irq_o, 0);
    fire(1);
    chk(irq_o, 1);
    rd(ADCMT_OFF_IRQ_STAT, 32'h1);
    wb(ADCMT_OFF_IRQ_EN, 1'b1, 32'h0);
    settle();
    chk(irq_o, 0);
    wb(ADCMT_OFF_IRQ_CLR, 1'b1, 32'h7);
    rd(ADCMT_OFF_IRQ_STAT, 32'h0);
    for (int t = 0; t < 8; t++) begin
      wb(ADCMT_OFF_MODE3, 1'b1, 32'(t * 16 + 2));
      n_irq = 0;
      repeat (2 * (t + 1)) fire(1);
      chk(n_irq, 2);
    end
    repeat (4) begin
      seed = xorshift(seed);
      wb(ADCMT_OFF_MODE3, 1'b1, seed);
      rd(ADCMT_OFF_MODE3, seed & 32'h73);
      settle();
      chk({rep_o, scan_o}, seed[1:0]);
    end
    wb(ADCMT_OFF_MODE3, 1'b1, 32'h73);
    @(posedge clk_i);
    abort_req <= 1'b1;
    @(posedge clk_i);
    abort_req <= 1'b0;
    settle();
    chk(rep_o, 0);
    rd(ADCMT_OFF_MODE3, 32'h71);
    // Interval conversions and the abort both latched
    rd(ADCMT_OFF_IRQ_STAT, 32'h3);
    // Reference off before standby
    wb(ADCMT_OFF_MODE1, 1'b1, 32'h0);
    settle();
    chk(ref_o, 0);
    rd(ADCMT_OFF_CORE_STAT, 32'h0);
    tally_and_finish();
  end
endmodule : adcmt_ctrl_test
